/* dsf_formatter.sv */
// Contract
// - extended blocks follow the standard header
// - channel octet one: module, selector two
// - channel block is exactly three octets
// - one channel block per faulty channel
// - octet two: channel number and direction
// - octet three low bits: fault kind
// - octet three high bits: channel data type
// - device header: length with selector zero
// - plain slave may append vendor payload
// - alarm stays pending until master acknowledges
// - status message withdrawn when condition clears
// - module status sent by basic unit
// - module status kind value is two
// - identifier bit one marks status report
// - slot octet zero for basic unit
// - specifier bits zero, reserved bits zero
// - two-bit entry per module from octet five
// - module status only on class four
//
// Purpose: stream extended diagnosis blocks octet by octet
// Assumes: caller streams the standard header first, then starts us
// Notes:   register port: addr, wdata, wr, rd, rdata one cycle later
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module dsf_formatter #(
  parameter int NCHAN = 8,   // channel table depth
  parameter int NMOD  = 8,   // modules in module status
  parameter int NVEND = 4    // vendor octets after device header
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // octet stream out
  output logic      [7:0]  tx_octet,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  // live status from the device
  input  wire logic        alarm_event,
  // interrupt
  output logic             irq
);

  localparam int MBYTES = (2 * NMOD + 7) / 8;  // entry octets
  localparam int CHW    = $clog2(NCHAN + 1);   // channel cursor width, one past the table

  // channel table: enable, module, channel, dir, fault, type
  logic [31:0] chan_reg [NCHAN];
  logic [31:0] ctrl_reg;                 // control bits
  logic [2*NMOD-1:0] modstat_reg;        // module entries, live
  logic [8*NVEND-1:0] vendor_reg;        // vendor payload
  logic [1:0]  irq_stat_reg;             // sticky events
  logic [1:0]  irq_en_reg;               // interrupt enables
  logic        alarm_reg;                // pending alarm
  logic        busy_reg;                 // stream active
  logic [31:0] rdata_reg;                // read data
  // state alias kept in package type
  typedef dsf_pkg::dsf_state_t dsf_fsm_t;
  dsf_fsm_t    state_reg;                // serializer state


  logic [$clog2(NCHAN+1)-1:0] ch_reg;    // channel cursor
  logic [5:0]  oc_reg;                   // octet cursor
  logic [7:0]  tx_octet_reg;
  logic        tx_valid_reg;
  logic        tx_last_reg;
  logic        done_pulse;               // stream finished

  // decode
  wire logic wr_ctrl  = wr && addr == dsf_pkg::OFS_CTRL;
  wire logic wr_en    = wr && addr == dsf_pkg::OFS_IRQ_EN;
  wire logic wr_clr   = wr && addr == dsf_pkg::OFS_IRQ_CLR;
  wire logic wr_mod   = wr && addr == dsf_pkg::OFS_MODSTAT;
  wire logic wr_vend  = wr && addr == dsf_pkg::OFS_VENDOR;
  wire logic wr_chan  = wr && addr >= dsf_pkg::OFS_CH_BASE &&
                        addr < dsf_pkg::OFS_CH_BASE + 8'(4 * NCHAN);
  wire logic [7:0] ch_waddr = (addr - dsf_pkg::OFS_CH_BASE) >> 2;
  wire logic start    = wr_ctrl && wdata[dsf_pkg::CTRL_START] && !busy_reg;
  wire logic ack      = wr_ctrl && wdata[dsf_pkg::CTRL_ALARM_ACK];
  wire logic class4   = ctrl_reg[dsf_pkg::CTRL_CLASS4];
  wire logic step     = !tx_valid_reg || tx_ready;  // output slot free

  // channel under the cursor
  wire logic [31:0] cur_ch = chan_reg[ch_reg[$clog2(NCHAN)-1:0]];
  wire logic        cur_on = ch_reg < NCHAN && cur_ch[31];
  logic [7:0] chan_octet;

  // channel encoder, one block at a time
  dsf_chan_enc u_chan (
    .module_num (cur_ch[5:0]),
    .chan_num   (cur_ch[11:6]),
    .direction  (cur_ch[13:12]),
    .fault_kind (cur_ch[18:14]),
    .data_kind  (cur_ch[21:19]),
    .index      (oc_reg[1:0]),
    .octet      (chan_octet)
  );

  // module status octets
  wire logic [5:0] mstat_len = 6'(4 + MBYTES);
  wire logic [7:0] mod_octet = 8'(modstat_reg >> (8 * (oc_reg - 6'h4)));
  wire logic [7:0] mstat_octet =
    (oc_reg == 6'h0) ? {dsf_pkg::SEL_DEVICE, mstat_len} :
    (oc_reg == 6'h1) ? {dsf_pkg::ID_STATUS, dsf_pkg::STATUS_KIND_MODULE} :
    (oc_reg == 6'h2) ? dsf_pkg::SLOT_BASIC_UNIT :
    (oc_reg == 6'h3) ? dsf_pkg::SPECIFIER_NONE :
                       mod_octet;

  // vendor device block: header counts itself
  wire logic [5:0] dev_len = 6'(1 + NVEND);
  wire logic [7:0] vend_octet = 8'(vendor_reg >> (8 * (oc_reg - 6'h1)));
  wire logic [7:0] dev_octet  = (oc_reg == 6'h0) ?
                                {dsf_pkg::SEL_DEVICE, dev_len} : vend_octet;

  // find next enabled channel at or after c
  function automatic logic [$clog2(NCHAN+1)-1:0] next_ch(input logic [$clog2(NCHAN+1)-1:0] c);
    logic [$clog2(NCHAN+1)-1:0] r;
    r = CHW'(NCHAN);
    for (int i = NCHAN - 1; i >= 0; i--) begin
      if (i >= c && chan_reg[i][31]) begin
        r = CHW'(i);
      end
    end
    return r;
  endfunction

  // register writes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg    <= dsf_pkg::CTRL_RESET;
      irq_en_reg  <= 2'h0;
      modstat_reg <= '0;
      vendor_reg  <= '0;
      for (int i = 0; i < NCHAN; i++) begin
        chan_reg[i] <= 32'h0;
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {28'h0, 1'h0, wdata[2:1], 1'h0};  // start and ack self-clear
      end
      if (wr_en) begin
        irq_en_reg <= wdata[1:0];
      end
      // status follows its condition, no latch so it withdraws itself
      if (wr_mod) begin
        modstat_reg <= wdata[2*NMOD-1:0];
      end
      if (wr_vend) begin
        vendor_reg <= wdata[8*NVEND-1:0];
      end
      if (wr_chan) begin
        chan_reg[ch_waddr[$clog2(NCHAN)-1:0]] <= wdata;
      end
    end
  end

  // alarm pending and sticky interrupt bits; set beats clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alarm_reg    <= 1'h0;
      irq_stat_reg <= 2'h0;
    end else begin
      alarm_reg    <= alarm_event || (alarm_reg && !ack);
      irq_stat_reg <= {alarm_event, done_pulse} |
                      (irq_stat_reg & ~(wr_clr ? wdata[1:0] : 2'h0));
    end
  end

  // serializer: channel blocks, then module status or vendor block
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= dsf_pkg::ST_IDLE;
      busy_reg     <= 1'h0;
      ch_reg       <= '0;
      oc_reg       <= 6'h0;
      tx_octet_reg <= 8'h0;
      tx_valid_reg <= 1'h0;
      tx_last_reg  <= 1'h0;
      done_pulse   <= 1'h0;
    end else begin
      done_pulse <= 1'h0;
      if (step) begin
        tx_valid_reg <= 1'h0;
        tx_last_reg  <= 1'h0;
      end
      unique case (state_reg)
        dsf_pkg::ST_IDLE: begin
          if (start) begin
            busy_reg  <= 1'h1;
            ch_reg    <= next_ch('0);
            oc_reg    <= 6'h0;
            state_reg <= dsf_pkg::ST_CHAN;
          end
        end
        dsf_pkg::ST_CHAN: begin
          if (step) begin
            if (cur_on) begin
              tx_octet_reg <= chan_octet;
              tx_valid_reg <= 1'h1;
              if (oc_reg == 6'(dsf_pkg::CHAN_BLOCK_LEN - 6'h1)) begin
                oc_reg <= 6'h0;
                ch_reg <= next_ch(ch_reg + 1'b1);
              end else begin
                oc_reg <= oc_reg + 6'h1;
              end
            end else if (class4) begin
              state_reg <= dsf_pkg::ST_MSTAT;
            end else if (ctrl_reg[dsf_pkg::CTRL_VEND_EN]) begin
              state_reg <= dsf_pkg::ST_VEND;
            end else begin
              state_reg  <= dsf_pkg::ST_IDLE;
              busy_reg   <= 1'h0;
              done_pulse <= 1'h1;
            end
          end
        end
        dsf_pkg::ST_MSTAT: begin
          if (step) begin
            tx_octet_reg <= mstat_octet;
            tx_valid_reg <= 1'h1;
            if (oc_reg == mstat_len - 6'h1) begin
              tx_last_reg <= 1'h1;
              oc_reg      <= 6'h0;
              state_reg   <= dsf_pkg::ST_IDLE;
              busy_reg    <= 1'h0;
              done_pulse  <= 1'h1;
            end else begin
              oc_reg <= oc_reg + 6'h1;
            end
          end
        end
        dsf_pkg::ST_VEND, dsf_pkg::ST_DEVHDR: begin
          if (step) begin
            tx_octet_reg <= dev_octet;
            tx_valid_reg <= 1'h1;
            if (oc_reg == dev_len - 6'h1) begin
              tx_last_reg <= 1'h1;
              oc_reg      <= 6'h0;
              state_reg   <= dsf_pkg::ST_IDLE;
              busy_reg    <= 1'h0;
              done_pulse  <= 1'h1;
            end else begin
              oc_reg <= oc_reg + 6'h1;
            end
          end
        end
        default: state_reg <= dsf_pkg::ST_IDLE;
      endcase
    end
  end

  // read mux, answer one cycle after the strobe
  wire logic wr_chan_rd = addr >= dsf_pkg::OFS_CH_BASE &&
                          addr < dsf_pkg::OFS_CH_BASE + 8'(4 * NCHAN);
  wire logic [31:0] rd_mux =
    (addr == dsf_pkg::OFS_CTRL)     ? ctrl_reg :
    (addr == dsf_pkg::OFS_STATUS)   ? {30'h0, alarm_reg, busy_reg} :
    (addr == dsf_pkg::OFS_IRQ_STAT) ? {30'h0, irq_stat_reg} :
    (addr == dsf_pkg::OFS_IRQ_EN)   ? {30'h0, irq_en_reg} :
    (addr == dsf_pkg::OFS_MODSTAT)  ? 32'(modstat_reg) :
    (addr == dsf_pkg::OFS_VENDOR)   ? 32'(vendor_reg) :
    wr_chan_rd                      ? chan_reg[ch_waddr[$clog2(NCHAN)-1:0]] : 32'h0;

  // read data and interrupt register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0;
      irq       <= 1'h0;
    end else begin
      rdata_reg <= rd ? rd_mux : 32'h0;
      irq       <= |(irq_stat_reg & irq_en_reg);
    end
  end

  assign rdata    = rdata_reg;
  assign tx_octet = tx_octet_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_last  = tx_last_reg;

  // channel first octet carries selector two
  chk_chan_selector: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == dsf_pkg::ST_CHAN && step && cur_on && oc_reg == 6'h0
    |=> tx_octet[7:6] == 2'h2 && tx_valid)
    else $error("channel selector wrong");
  // channel block never passes three octets
  chk_chan_length: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == dsf_pkg::ST_CHAN |-> oc_reg < 6'h3)
    else $error("channel block too long");
  // alarm holds until acknowledged
  chk_alarm_hold: assert property (@(posedge clock) disable iff (!rstn)
    alarm_reg && !ack |=> alarm_reg)
    else $error("alarm dropped without ack");
  // module status second octet
  chk_mstat_kind: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == dsf_pkg::ST_MSTAT && step && oc_reg == 6'h1 |=> tx_octet == 8'h82)
    else $error("module status kind wrong");
  // slot octet zero
  chk_mstat_slot: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == dsf_pkg::ST_MSTAT && step && oc_reg == 6'h2 |=> tx_octet == 8'h00)
    else $error("slot not basic unit");
  // specifier octet zero
  chk_mstat_spec: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == dsf_pkg::ST_MSTAT && step && oc_reg == 6'h3 |=> tx_octet == 8'h00)
    else $error("specifier not zero");
  // module status only on class four
  chk_class4_only: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == dsf_pkg::ST_MSTAT |-> class4)
    else $error("module status without class four");
  // device header counts itself
  chk_dev_header: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == dsf_pkg::ST_VEND && step && oc_reg == 6'h0
    |=> tx_octet == {2'h0, 6'(1 + NVEND)})
    else $error("device header wrong");

endmodule

/* dsf_pkg.sv */
// Purpose: constants and types shared by the diagnosis block formatter
// Assumes: octet fields as laid out on the wire, bit 0 first in each octet
// Notes:   offsets are byte addresses on the plain register port
package dsf_pkg;

  // selector codes in the upper two bits of a block's first octet
  localparam logic [1:0] SEL_DEVICE  = 2'h0;
  localparam logic [1:0] SEL_CHANNEL = 2'h2;

  // channel block length is implied, always three octets
  localparam logic [5:0] CHAN_BLOCK_LEN = 6'h03;

  // module status message fields
  localparam logic [6:0] STATUS_KIND_MODULE = 7'h02;
  localparam logic       ID_STATUS          = 1'h1;
  localparam logic [7:0] SLOT_BASIC_UNIT    = 8'h00;
  localparam logic [7:0] SPECIFIER_NONE     = 8'h00;
  localparam logic [5:0] MSTAT_HDR_LEN      = 6'h04;
  localparam logic [5:0] DEV_HDR_LEN        = 6'h01;

  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFS_MODSTAT  = 8'h14;
  localparam logic [7:0] OFS_VENDOR   = 8'h18;
  localparam logic [7:0] OFS_CH_BASE  = 8'h40;

  // reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] IRQ_EN_RESET = 32'h0000_0000;

  // control bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_CLASS4 = 1;
  localparam int CTRL_VEND_EN = 2;
  localparam int CTRL_ALARM_ACK = 3;

  // interrupt bit positions
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ALARM = 1;

  // serializer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHAN, ST_MSTAT, ST_DEVHDR, ST_VEND
  } dsf_state_t;

endpackage

/* dsf_chan_enc.sv */
// Purpose: encode one channel block as three octets
// Assumes: inputs steady while the octets are read
// Notes:   pure combinational, used once per channel in turn
`timescale 1ns/10ps
module dsf_chan_enc (
  // channel fields
  input  wire logic [5:0] module_num,
  input  wire logic [5:0] chan_num,
  input  wire logic [1:0] direction,
  input  wire logic [4:0] fault_kind,
  input  wire logic [2:0] data_kind,
  input  wire logic [1:0] index,
  // selected octet
  output logic      [7:0] octet
);

  // octet 1: module number under the channel selector
  wire logic [7:0] oct1 = {dsf_pkg::SEL_CHANNEL, module_num};
  // octet 2: channel number under the direction
  wire logic [7:0] oct2 = {direction, chan_num};
  // octet 3: fault kind under the data type
  wire logic [7:0] oct3 = {data_kind, fault_kind};

  // ascending order, fixed length of three
  assign octet = (index == 2'h0) ? oct1 : (index == 2'h1) ? oct2 : oct3;

endmodule

/* dsf_sink.sv */
// Purpose: far-side model of the octet stream, the master collecting diagnosis
// Assumes: one clock, accepts on tx_valid and tx_ready high at a rising edge
// Notes:   slow mode drops ready every other cycle to stall the formatter
`timescale 1ns/10ps
module dsf_sink (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // stream from the formatter
  input  wire logic [7:0] tx_octet,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // pacing choice of the bench
  input  wire logic       slow
);
  logic [7:0] got[$];       // octets taken, in arrival order
  logic       got_last[$];  // last flag beside each octet

  // ready pacing: toggling ready makes each octet loaded on an accepting edge wait one cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'h0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'h1;
    end
  end

  // capture: octets kept in arrival order as they move
  always @(posedge clock) begin
    if (rstn && tx_valid && tx_ready) begin
      got.push_back(tx_octet);
      got_last.push_back(tx_last);
    end
  end
endmodule

/* dsf_formatter_test.sv */
// Purpose: self-checking bench for the diagnosis block formatter
// Assumes: defaults of eight channels, eight modules, four vendor octets
// Notes:   expected octets are rebuilt here from the table written by the bench
`timescale 1ns/10ps
module dsf_formatter_test;
  logic        clock;        // 25 MHz system clock
  logic        rstn;         // async reset, active low
  logic [7:0]  addr;         // register address
  logic [31:0] wdata;        // register write data
  logic        wr;           // write strobe
  logic        rd;           // read strobe
  logic [31:0] rdata;        // register read data
  logic [7:0]  tx_octet;     // stream octet
  logic        tx_valid;     // stream valid
  logic        tx_last;      // stream last
  logic        tx_ready;     // sink ready
  logic        alarm_event;  // alarm pulse
  logic        irq;          // level interrupt
  logic        slow;         // sink pacing
  logic [31:0] cfg[8];       // channel table as written
  logic [31:0] modstat;      // module entries as written
  logic [31:0] vend;         // vendor payload as written
  int          n_mismatch;
  int          comparisons;
  int          cyc;

  dsf_formatter #(.NCHAN(8), .NMOD(8), .NVEND(4)) u_dsf_formatter (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_octet(tx_octet), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .alarm_event(alarm_event), .irq(irq));

  dsf_sink u_dsf_sink (
    .clock(clock), .rstn(rstn), .tx_octet(tx_octet), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow));

  // clock generation, 40 ns period
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clock);
    wr    <= 1'h0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clock);
    rd   <= 1'h0;
    #1 d = rdata;
  endtask

  // reset values and an unmapped place
  task automatic t_reset_values();
    logic [31:0] d;
    rd_reg(dsf_pkg::OFS_CTRL, d);
    chk("ctrl reset", d, dsf_pkg::CTRL_RESET);
    rd_reg(dsf_pkg::OFS_IRQ_EN, d);
    chk("irq_en reset", d, dsf_pkg::IRQ_EN_RESET);
    rd_reg(8'h30, d);
    chk("unmapped", d, 32'h0000_0000);
    chk("irq idle", {31'h0, irq}, 32'h0000_0000);
  endtask

  // start a stream with the given control bits and judge every octet
  task automatic run_stream(input logic [31:0] ctrl, input logic pace);
    logic [7:0]  e[$];
    logic [31:0] d;
    int          k;
    for (int i = 0; i < 8; i++) begin
      if (cfg[i][31]) begin
        e.push_back({dsf_pkg::SEL_CHANNEL, cfg[i][5:0]});
        e.push_back({cfg[i][13:12], cfg[i][11:6]});
        e.push_back({cfg[i][21:19], cfg[i][18:14]});
      end
    end
    k = e.size();
    if (ctrl[dsf_pkg::CTRL_CLASS4]) begin
      e.push_back({dsf_pkg::SEL_DEVICE, dsf_pkg::MSTAT_HDR_LEN + 6'h02});
      e.push_back({dsf_pkg::ID_STATUS, dsf_pkg::STATUS_KIND_MODULE});
      e.push_back(8'h00);
      e.push_back(8'h00);
      e.push_back(modstat[7:0]);
      e.push_back(modstat[15:8]);
    end else if (ctrl[dsf_pkg::CTRL_VEND_EN]) begin
      e.push_back({dsf_pkg::SEL_DEVICE, 6'h05});
      for (int b = 0; b < 4; b++) e.push_back(vend[8*b +: 8]);
    end
    u_dsf_sink.got.delete();
    u_dsf_sink.got_last.delete();
    slow <= pace;
    wr_reg(dsf_pkg::OFS_CTRL, ctrl);
    d = 32'h1;
    for (int n = 0; n < 400 && d[0] !== 1'h0; n++) rd_reg(dsf_pkg::OFS_STATUS, d);
    chk("busy end", d[0], 1'h0);
    // busy drops as the final octet is loaded; a stalled sink takes it later
    repeat (3) @(posedge clock);
    #1 chk("stream drained", {31'h0, tx_valid}, 32'h0);
    chk("octet count", u_dsf_sink.got.size(), e.size());
    for (int i = 0; i < e.size() && i < u_dsf_sink.got.size(); i++) begin
      chk("octet", {24'h0, u_dsf_sink.got[i]}, {24'h0, e[i]});
      chk("last", u_dsf_sink.got_last[i], (i == e.size() - 1) && (e.size() > k));
    end
    rd_reg(dsf_pkg::OFS_IRQ_STAT, d);
    chk("done stat", d[dsf_pkg::IRQ_DONE], 1'h1);
    wr_reg(dsf_pkg::OFS_IRQ_CLR, 32'h0000_0001);
  endtask

  // channel table with edge values, one entry left out
  task automatic t_streams();
    for (int i = 0; i < 8; i++) begin
      cfg[i] = {(i != 3), 9'h0, 3'(i), 5'(i * 4 + 1), 2'(i), 6'(63 - i * 9), 6'(i == 0 ? 63 : i)};
      wr_reg(dsf_pkg::OFS_CH_BASE + 8'(4 * i), cfg[i]);
    end
    modstat = 32'h0000_1be4;
    vend    = 32'ha5c3_0f81;
    wr_reg(dsf_pkg::OFS_MODSTAT, modstat);
    wr_reg(dsf_pkg::OFS_VENDOR, vend);
    run_stream(32'h0000_0003, 1'h1);
    modstat = 32'h0000_0000;
    wr_reg(dsf_pkg::OFS_MODSTAT, modstat);
    run_stream(32'h0000_0003, 1'h0);
    run_stream(32'h0000_0005, 1'h1);
    run_stream(32'h0000_0001, 1'h0);
  endtask

  // alarm kept until acknowledged, interrupt masked then raised
  task automatic t_alarm();
    logic [31:0] d;
    wr_reg(dsf_pkg::OFS_IRQ_EN, 32'h0000_0000);
    @(posedge clock);
    alarm_event <= 1'h1;
    @(posedge clock);
    alarm_event <= 1'h0;
    repeat (3) @(posedge clock);
    #1 chk("irq masked", irq, 1'h0);
    wr_reg(dsf_pkg::OFS_IRQ_EN, 32'h0000_0002);
    repeat (3) @(posedge clock);
    #1 chk("irq raised", irq, 1'h1);
    wr_reg(dsf_pkg::OFS_IRQ_CLR, 32'h0000_0002);
    repeat (2) @(posedge clock);
    #1 chk("irq cleared", irq, 1'h0);
    rd_reg(dsf_pkg::OFS_STATUS, d);
    chk("alarm held", d[1], 1'h1);
    wr_reg(dsf_pkg::OFS_CTRL, 32'h0000_0008);
    rd_reg(dsf_pkg::OFS_STATUS, d);
    chk("alarm acked", d[1], 1'h0);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rstn = 1'h0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'h0;
    rd = 1'h0;
    alarm_event = 1'h0;
    slow = 1'h0;
    n_mismatch = 0;
    comparisons = 0;
    cyc = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'h1;
    t_reset_values();
    t_streams();
    t_alarm();
    end_of_test();
  end
endmodule
